/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   reg i_clk_sys = 1'b0, i_rst_b = 1'b0, i_capture_start_call = 1'b0, i_capture_stop_call = 1'b0;
   reg i_mem_ready = 1'b1, i_interlaced = 1'b1, stall = 1'b0, hi = 1'b0;
   reg [31:0] i_frame_stride = 32'h0000_4000;
   reg [7:0] i_frame_buf_count = 8'h01;
   reg [15:0] i_resync_frames = 16'h0000;
   reg [10:0] i_allotment = 11'h000;
   wire [31:0] i_field0_base = 32'h0000_1000, i_field1_offset = 32'h0000_0800, i_field_pixels = 32'h0000_0008;
   wire [31:0] i_line_stride = 32'h0000_0100, o_mem_addr;
   wire [15:0] i_line_pixels = 16'h0004, i_pix_data, o_mem_data;
   wire i_pix_valid, o_mem_wr, o_watermark_irq_input, o_overflow_err, o_capture_active, o_synced, o_second_field;
   integer err_total = 0, n_checks = 0, nw = 0, t;
   vcfw_field_writer i_vcfw_field_writer (.*);
   vcfw_decoder_model i_vcfw_decoder_model (.i_clk_sys(i_clk_sys), .o_pix_valid(i_pix_valid), .o_pix_data(i_pix_data));
   always #20 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) if (stall) #1 i_mem_ready = ~i_mem_ready;
   task end_of_test;
      begin
         $display("checks %0d errors %0d", n_checks, err_total);
         if (err_total == 0 && n_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   function [31:0] ea(input integer n);
      integer p, f;
      begin
         p = n % 8;
         f = (n / 8) % 2;
         ea = i_field0_base + (n / 16) % i_frame_buf_count * i_frame_stride + 2 * (p % 4);
         ea = ea + (i_interlaced ? f * i_field1_offset + p / 4 * i_line_stride : (f + p / 4 * 2) * i_line_stride);
      end
   endfunction
   always @(negedge i_clk_sys) begin
      if (o_watermark_irq_input === 1'b1) hi = 1'b1;
      if (o_mem_wr === 1'b1 && i_mem_ready) begin
         cmp(o_mem_addr, ea(nw));
         cmp({16'h0000, o_mem_data}, 32'h0000_0100 + nw);
         cmp({31'h0, o_second_field}, ((nw + 1) / 8) % 2);
         nw = nw + 1;
      end
   end
   task px(input integer n, input [15:0] v, input [15:0] inc);
      for (t = 0; t < n; t = t + 1) begin
         i_vcfw_decoder_model.send(v);
         v = v + inc;
      end
   endtask
   task waitn(input integer n);
      begin
         for (t = 0; t < 5000 && nw < n; t = t + 1) @(posedge i_clk_sys);
         repeat (50) @(posedge i_clk_sys);
         #1 cmp(nw, n);
         if (nw < n) end_of_test;
      end
   endtask
   task restart;
      begin
         @(posedge i_clk_sys) #1 i_capture_start_call = 1'b1;
         repeat (3) @(posedge i_clk_sys);
         #1 i_capture_start_call = 1'b0;
         repeat (4) @(posedge i_clk_sys);
         #1 nw = 0;
         hi = 1'b0;
         cmp({29'h0, o_capture_active, o_overflow_err, o_synced}, 32'h4);
      end
   endtask
   task sc_fields;
      begin
         stall = 1'b1;
         restart;
         px(100, 16'h0001, 16'h0000);
         px(1, 16'hff00, 16'h0000);
         px(410, 16'h0100, 16'h0001);
         repeat (4) @(posedge i_clk_sys);
         cmp({31'h0, hi}, 32'h0);
         px(1, 16'h029a, 16'h0000);
         waitn(411);
         cmp({31'h0, hi}, 32'h1);
         stall = 1'b0;
      end
   endtask
   task sc_resync;
      begin
         @(posedge i_clk_sys) #1 i_interlaced = 1'b0;
         i_frame_buf_count = 8'h02;
         i_resync_frames = 16'h0002;
         i_allotment = 11'h200;
         restart;
         i_mem_ready = 1'b1;
         px(10, 16'h0001, 16'h0000);
         px(1, 16'hff00, 16'h0000);
         px(501, 16'h0100, 16'h0001);
         waitn(32);
         cmp({31'h0, o_synced}, 32'h0);
         // Refill to the mark with no sync word: hunt drains all and writes nothing
         px(43, 16'h0001, 16'h0000);
         repeat (600) @(posedge i_clk_sys);
         #1 cmp(nw, 32);
         cmp({30'h0, o_synced, o_watermark_irq_input}, 32'h0);
      end
   endtask
   task sc_overflow;
      begin
         @(posedge i_clk_sys) #1 i_mem_ready = 1'b0;
         restart;
         px(1, 16'hff00, 16'h0000);
         px(1030, 16'h0100, 16'h0001);
         repeat (4) @(posedge i_clk_sys);
         #1 cmp({31'h0, o_overflow_err}, 32'h1);
         i_capture_stop_call = 1'b1;
         repeat (4) @(posedge i_clk_sys);
         #1 i_capture_stop_call = 1'b0;
         cmp({30'h0, o_capture_active, o_watermark_irq_input}, 32'h0);
         i_mem_ready = 1'b1;
         restart;
      end
   endtask
   initial begin
      repeat (20) @(posedge i_clk_sys);
      #1 i_rst_b = 1'b1;
      sc_fields;
      sc_resync;
      sc_overflow;
      end_of_test;
   end
endmodule

/* File: dv/vcfw_decoder_model.sv */
`timescale 1ns/100ps
module vcfw_decoder_model (
   input wire i_clk_sys,
   output reg o_pix_valid,
   output reg [15:0] o_pix_data
);
   initial {o_pix_valid, o_pix_data} = 17'h0_0000;
   // One-cycle strobe, data held two cycles, then scrambled
   task send(input [15:0] pix);
      begin
         @(posedge i_clk_sys) #1 {o_pix_valid, o_pix_data} = {1'b1, pix};
         @(posedge i_clk_sys) #1 o_pix_valid = 1'b0;
         @(posedge i_clk_sys) #1 o_pix_data = ~pix;
      end
   endtask
endmodule

/* File: dv/vcfw_properties.sv */
`timescale 1ns/100ps
module vcfw_properties (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire i_capture_start_call,
   input wire i_capture_stop_call,
   input wire i_mem_ready,
   input wire o_mem_wr,
   input wire [31:0] o_mem_addr,
   input wire [15:0] o_mem_data,
   input wire o_watermark_irq_input,
   input wire o_overflow_err,
   input wire o_capture_active,
   input wire o_synced,
   input wire o_second_field
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   // Start and stop abandon a pending write; start reaches the engine two cycles late
   property p_hold;
      o_mem_wr && !i_mem_ready |=>
         (o_mem_wr && $stable({o_mem_addr, o_mem_data})) || !o_capture_active || $past(i_capture_start_call, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("write not held");
   property p_gap; o_mem_wr && i_mem_ready |=> !o_mem_wr; endproperty
   a_gap: assert property (p_gap) else $error("write not spaced");
   property p_stop; i_capture_stop_call |-> ##[1:4] !(o_capture_active || o_synced); endproperty
   a_stop: assert property (p_stop) else $error("stop ignored");
   property p_quiet; !o_capture_active [*4] |-> !o_watermark_irq_input; endproperty
   a_quiet: assert property (p_quiet) else $error("irq while idle");
   property p_sticky; !i_capture_start_call [*4] ##0 o_overflow_err |=> o_overflow_err; endproperty
   a_sticky: assert property (p_sticky) else $error("overflow lost");
   property p_full; $rose(o_overflow_err) && o_capture_active |-> o_watermark_irq_input; endproperty
   a_full: assert property (p_full) else $error("overflow below mark");
   property p_act; $rose(o_mem_wr) |-> o_capture_active; endproperty
   a_act: assert property (p_act) else $error("write while idle");
   property p_resync; $fell(o_synced) && o_capture_active |-> ##[0:2] !o_second_field; endproperty
   a_resync: assert property (p_resync) else $error("hunt mid frame");
   c_wr: cover property (o_mem_wr && i_mem_ready);
   c_sf: cover property ($rose(o_second_field));
   c_ovf: cover property ($rose(o_overflow_err));
   c_rehunt: cover property ($fell(o_synced) && o_capture_active);
endmodule
bind vcfw_field_writer vcfw_properties i_vcfw_properties (.*);

/* File: logic/vcfw_defs.vh */
`ifndef VCFW_DEFS_VH
`define VCFW_DEFS_VH
`define VCFW_FIFO_DEPTH 1024
`define VCFW_FIFO_AW 10
`define VCFW_HALF_MARK 512
`define VCFW_PIX_W 16
`define VCFW_ADDR_W 32
`define VCFW_SYNC_CODE 16'hff00
`define VCFW_PIX_BYTES 32'h0000_0002
`define VCFW_ST_IDLE 2'h0
`define VCFW_ST_HUNT 2'h1
`define VCFW_ST_XFER 2'h2
`endif

/* File: logic/vcfw_field_writer.v */
`timescale 1ns/100ps
`include "vcfw_defs.vh"
module vcfw_field_writer #(
   parameter DEPTH = `VCFW_FIFO_DEPTH,
   parameter AW = `VCFW_FIFO_AW,
   parameter HALF = `VCFW_HALF_MARK,
   parameter [15:0] SYNC_CODE = `VCFW_SYNC_CODE
) (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire i_pix_valid,
   input wire [15:0] i_pix_data,
   input wire i_capture_start_call,
   input wire i_capture_stop_call,
   input wire [31:0] i_field0_base,
   input wire [31:0] i_field1_offset,
   input wire [31:0] i_frame_stride,
   input wire [7:0] i_frame_buf_count,
   input wire [31:0] i_field_pixels,
   input wire [15:0] i_line_pixels,
   input wire [31:0] i_line_stride,
   input wire i_interlaced,
   input wire [15:0] i_resync_frames,
   input wire [AW:0] i_allotment,
   input wire i_mem_ready,
   output reg o_mem_wr,
   output reg [31:0] o_mem_addr,
   output reg [15:0] o_mem_data,
   output wire o_watermark_irq_input,
   output reg o_overflow_err,
   output reg o_capture_active,
   output reg o_synced,
   output reg o_second_field
);
   reg [15:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] fill;
   reg pv_s1, pv_s2, st_s1, st_s2, sp_s1, sp_s2;
   reg [15:0] pd_s1, pd_s2;
   reg [1:0] state;
   reg [AW:0] drained;
   reg [31:0] field_cnt;
   reg [15:0] col_cnt;
   reg [31:0] line_base;
   reg [31:0] frame_base;
   reg [7:0] frame_idx;
   reg [15:0] frame_cnt;
   reg irq_en;
   reg [15:0] head;
   wire push;
   wire pop;
   wire fifo_rst;
   wire [AW:0] allot;

   // True when the pop in hand is the last one of this service
   function allot_done;
      input [AW:0] cnt;
      input [AW:0] lim;
      begin
         allot_done = ({1'b0, cnt} + {{(AW+1){1'b0}}, 1'b1} >= {1'b0, lim});
      end
   endfunction

   // Decoder pixels and controls arrive from another domain
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pv_s1 <= 1'b0;
         pv_s2 <= 1'b0;
         pd_s1 <= 16'h0000;
         pd_s2 <= 16'h0000;
         st_s1 <= 1'b0;
         st_s2 <= 1'b0;
         sp_s1 <= 1'b0;
         sp_s2 <= 1'b0;
      end else begin
         pv_s1 <= i_pix_valid;
         pv_s2 <= pv_s1;
         pd_s1 <= i_pix_data;
         pd_s2 <= pd_s1;
         st_s1 <= i_capture_start_call;
         st_s2 <= st_s1;
         sp_s1 <= i_capture_stop_call;
         sp_s2 <= sp_s1;
      end
   end

   assign fifo_rst = st_s2;
   assign push = pv_s2 && (fill != DEPTH[AW:0]) && !fifo_rst;
   assign pop = (state != `VCFW_ST_IDLE) && (fill != {(AW+1){1'b0}}) && !o_mem_wr && !fifo_rst;
   assign allot = (i_allotment == {(AW+1){1'b0}}) ? HALF[AW:0] : i_allotment;
   // Level-based: falls when reads take the fill below half, when start's FIFO reset empties it, or when stop clears irq_en
   assign o_watermark_irq_input = irq_en && (fill >= HALF[AW:0]);

   always @(posedge i_clk_sys) begin
      if (push)
         mem[wr_ptr] <= pd_s2;
   end

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         fill <= {(AW+1){1'b0}};
         o_overflow_err <= 1'b0;
         irq_en <= 1'b0;
         o_capture_active <= 1'b0;
      end else begin
         if (fifo_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill <= {(AW+1){1'b0}};
            o_overflow_err <= 1'b0;
         end else begin
            if (push)
               wr_ptr <= wr_ptr + 1'b1;
            if (pop)
               rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
               fill <= fill + 1'b1;
            else if (pop && !push)
               fill <= fill - 1'b1;
            if (pv_s2 && fill == DEPTH[AW:0])
               o_overflow_err <= 1'b1;
         end
         if (sp_s2) begin
            irq_en <= 1'b0;
            o_capture_active <= 1'b0;
         end else if (st_s2) begin
            irq_en <= 1'b1;
            o_capture_active <= 1'b1;
         end
      end
   end

   always @* begin
      head = mem[rd_ptr];
   end

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= `VCFW_ST_IDLE;
         drained <= {(AW+1){1'b0}};
         field_cnt <= 32'h0000_0000;
         col_cnt <= 16'h0000;
         line_base <= 32'h0000_0000;
         frame_base <= 32'h0000_0000;
         frame_idx <= 8'h00;
         frame_cnt <= 16'h0000;
         o_synced <= 1'b0;
         o_second_field <= 1'b0;
         o_mem_wr <= 1'b0;
         o_mem_addr <= 32'h0000_0000;
         o_mem_data <= 16'h0000;
      end else if (st_s2 || sp_s2) begin
         state <= `VCFW_ST_IDLE;
         drained <= {(AW+1){1'b0}};
         field_cnt <= 32'h0000_0000;
         col_cnt <= 16'h0000;
         line_base <= i_field0_base;
         frame_base <= i_field0_base;
         frame_idx <= 8'h00;
         frame_cnt <= 16'h0000;
         o_synced <= 1'b0;
         o_second_field <= 1'b0;
         o_mem_wr <= 1'b0;
      end else begin
         if (o_mem_wr && i_mem_ready)
            o_mem_wr <= 1'b0;
         case (state)
            `VCFW_ST_IDLE: begin
               drained <= {(AW+1){1'b0}};
               if (o_watermark_irq_input && !o_mem_wr)
                  state <= o_synced ? `VCFW_ST_XFER : `VCFW_ST_HUNT;
            end
            `VCFW_ST_HUNT: begin
               if (pop) begin
                  drained <= drained + 1'b1;
                  if (head == SYNC_CODE) begin
                     o_synced <= 1'b1;
                     state <= `VCFW_ST_XFER;
                     field_cnt <= 32'h0000_0000;
                     col_cnt <= 16'h0000;
                     o_second_field <= 1'b0;
                     line_base <= frame_base;
                  end
                  // A sync word that ends the allotment still ends the service
                  if (allot_done(drained, allot))
                     state <= `VCFW_ST_IDLE;
               end
            end
            `VCFW_ST_XFER: begin
               if (pop) begin
                  drained <= drained + 1'b1;
                  o_mem_wr <= 1'b1;
                  o_mem_data <= head;
                  o_mem_addr <= line_base + {15'h0000, col_cnt, 1'b0};
                  if (allot_done(drained, allot))
                     state <= `VCFW_ST_IDLE;
                  if (col_cnt + 16'h0001 >= i_line_pixels) begin
                     col_cnt <= 16'h0000;
                     line_base <= line_base + (i_interlaced ? i_line_stride : {i_line_stride[30:0], 1'b0});
                  end else
                     col_cnt <= col_cnt + 16'h0001;
                  if (field_cnt + 32'h1 >= i_field_pixels) begin
                     field_cnt <= 32'h0000_0000;
                     col_cnt <= 16'h0000;
                     if (!o_second_field) begin
                        o_second_field <= 1'b1;
                        line_base <= i_interlaced ? frame_base + i_field1_offset : frame_base + i_line_stride;
                     end else begin
                        o_second_field <= 1'b0;
                        if (frame_idx + 8'h01 >= i_frame_buf_count) begin
                           frame_idx <= 8'h00;
                           frame_base <= i_field0_base;
                           line_base <= i_field0_base;
                        end else begin
                           frame_idx <= frame_idx + 8'h01;
                           frame_base <= frame_base + i_frame_stride;
                           line_base <= frame_base + i_frame_stride;
                        end
                        if (frame_cnt + 16'h0001 == i_resync_frames) begin
                           frame_cnt <= 16'h0000;
                           o_synced <= 1'b0;
                           state <= `VCFW_ST_IDLE;
                        end else
                           frame_cnt <= frame_cnt + 16'h0001;
                     end
                  end else
                     field_cnt <= field_cnt + 32'h1;
               end
            end
            default: state <= `VCFW_ST_IDLE;
         endcase
      end
   end
endmodule
